// *** hdl/ivc_pkg.sv ***
// Constants for the nested vector interrupt front end
package ivc_pkg;
    localparam int NUM_LINES = 32;
    localparam int NUM_CHAN = 8;
    localparam int LINES_PER_CHAN = 4;
    localparam logic [5:0] EXC_BASE = 6'h10;
    localparam logic [2:0] PRIO_NONE = 3'h4;
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_PEND_SET = 8'h04;
    localparam logic [7:0] OFS_PEND_CLR = 8'h08;
    localparam logic [7:0] OFS_PATH_SEL = 8'h0c;
    localparam logic [7:0] OFS_TRIG_CFG = 8'h10;
    localparam logic [7:0] OFS_CHAN_SEL = 8'h14;
    localparam logic [7:0] OFS_PRIO_LO = 8'h18;
    localparam logic [7:0] OFS_PRIO_HI = 8'h1c;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_ACTIVE = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_CHAN = 16'h0000;
    localparam logic [63:0] RST_PRIO = 64'h0000_0000_0000_0000;
    localparam logic RST_MASK = 1'b0;
    localparam int STAT_REQ_BIT = 8;
endpackage

// *** hdl/ivc_top.sv ***
// Nested vector interrupt controller with trigger selection and APB slave
// Overview of operation
// [R1] Thirty-two independent request lines, one source per line.
// [R2] Dedicated peripheral requests are always level treated, fixed line.
// [R3] Fabric requests select level or rising edge per line.
// [R4] Level line keeps re-pending while its input stays high.
// [R5] Edge line gives one service per rising transition only.
// [R6] Service code must clear held sources, else level re-enters.
// [R7] Two-bit priority per line, zero most urgent, three least.
// [R8] More urgent request preempts a less urgent service in progress.
// [R9] Line zero maps to exception sixteen, onward in order.
// [R10] Software may force a line pending without a request.
// [R11] Software clear resets only pending bit, never the source.
// [R12] Per-line enable, settable or clearable at any time.
// [R13] Software disables a line before changing its priority.
// [R14] Eight fabric channels, each routed to one of four lines.
// [R15] Global mask readable and writable for save and restore.
// [R16] Edge detector emits one-cycle pulse per fabric rising edge.
// [R17] Present only if more urgent than active; low line wins ties.
// [R18] Entry acknowledge clears pending; new requests set it again.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
module ivc_top
    import ivc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [31:0] fixed_req,
    input wire logic [7:0] fabric_ch,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq_req,
    output logic [4:0] irq_line,
    output logic [5:0] exc_num,
    input wire logic ack_enter,
    input wire logic ack_exit,
    input wire logic [4:0] ack_exit_line
);
    logic [31:0] en_q, en_d;
    logic [31:0] pend_q, pend_d;
    logic [31:0] path_q, trig_q;
    logic [15:0] chan_q;
    logic [63:0] prio_q;
    logic mask_q;
    logic [31:0] act_q, act_d;
    logic [31:0] prev_q;
    logic req_q;
    logic [4:0] line_q;
    logic [5:0] exc_q;
    logic [31:0] fab_line, line_in, edge_sel, edge_pulse, src_evt;
    logic [31:0] cand;
    logic [2:0] best_p, act_p;
    logic [4:0] best_n;
    logic present;

    // Bus decode
    wire wr_en = psel && penable && pwrite;
    wire hit_en = paddr == OFS_ENABLE;
    wire hit_ps = paddr == OFS_PEND_SET;
    wire hit_pc = paddr == OFS_PEND_CLR;
    wire hit_path = paddr == OFS_PATH_SEL;
    wire hit_trig = paddr == OFS_TRIG_CFG;
    wire hit_ch = paddr == OFS_CHAN_SEL;
    wire hit_plo = paddr == OFS_PRIO_LO;
    wire hit_phi = paddr == OFS_PRIO_HI;
    wire hit_mask = paddr == OFS_MASK;
    wire hit_act = paddr == OFS_ACTIVE;
    wire hit_st = paddr == OFS_STATUS;
    wire mapped = hit_en | hit_ps | hit_pc | hit_path | hit_trig | hit_ch
        | hit_plo | hit_phi | hit_mask | hit_act | hit_st;
    wire [31:0] sw_set = (wr_en && hit_ps) ? pwdata : RST_WORD;
    wire [31:0] sw_clr = (wr_en && hit_pc) ? pwdata : RST_WORD;
    wire [31:0] ack_clr = (ack_enter && req_q) ?
        (32'h0000_0001 << line_q) : RST_WORD;
    wire [31:0] exit_clr = ack_exit ?
        (32'h0000_0001 << ack_exit_line) : RST_WORD;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Fabric channel demux onto its group of four lines
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_line
            localparam int CH = g / LINES_PER_CHAN;
            localparam logic [1:0] SUB = 2'(g % LINES_PER_CHAN);
            assign fab_line[g] = fabric_ch[CH] &&
                (chan_q[2*CH +: 2] == SUB); // [R14]
        end
    endgenerate

    assign line_in = (path_q & fab_line) | (~path_q & fixed_req); // [R1] [R2]
    assign edge_sel = path_q & trig_q; // [R3]
    assign edge_pulse = line_in & ~prev_q & edge_sel; // [R16] [R5]
    assign src_evt = (line_in & ~edge_sel) | edge_pulse; // [R4]
    assign cand = mask_q ? RST_WORD : (pend_q & en_q); // [R12] [R15]

    // Set wins over every clear
    assign pend_d = (pend_q & ~sw_clr & ~ack_clr) | src_evt | sw_set; // [R10] [R11] [R18]
    assign act_d = (act_q & ~exit_clr) | ack_clr; // [R8]
    assign en_d = (wr_en && hit_en) ? pwdata : en_q;

    // Urgency search; lower line wins ties
    always_comb begin
        best_p = PRIO_NONE;
        best_n = 5'h00;
        act_p = PRIO_NONE;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (cand[i] && ({1'b0, prio_q[2*i +: 2]} <= best_p)) begin // [R7] [R17]
                best_p = {1'b0, prio_q[2*i +: 2]};
                best_n = 5'(i);
            end
            if (act_q[i] && ({1'b0, prio_q[2*i +: 2]} < act_p)) begin
                act_p = {1'b0, prio_q[2*i +: 2]};
            end
        end
    end

    assign present = best_p < act_p; // [R8] [R17]

    always_ff @(posedge mclk) begin
        if (srst) begin
            en_q <= RST_WORD;
            pend_q <= RST_WORD;
            path_q <= RST_WORD;
            trig_q <= RST_WORD;
            chan_q <= RST_CHAN;
            prio_q <= RST_PRIO;
            mask_q <= RST_MASK;
            act_q <= RST_WORD;
            prev_q <= RST_WORD;
        end else begin
            en_q <= en_d;
            pend_q <= pend_d;
            act_q <= act_d;
            prev_q <= line_in;
            if (wr_en && hit_path) begin
                path_q <= pwdata;
            end
            if (wr_en && hit_trig) begin
                trig_q <= pwdata;
            end
            if (wr_en && hit_ch) begin
                chan_q <= pwdata[15:0];
            end
            if (wr_en && hit_plo) begin
                prio_q[31:0] <= pwdata;
            end
            if (wr_en && hit_phi) begin
                prio_q[63:32] <= pwdata;
            end
            if (wr_en && hit_mask) begin
                mask_q <= pwdata[0]; // [R15]
            end
        end
    end

    // Request presented to the core; line held until taken or withdrawn
    wire ack_take = ack_enter && req_q;
    wire line_keep = req_q && !ack_take;
    wire line_moved = req_q && (best_n != line_q);
    wire [5:0] exc_next = 6'(EXC_BASE + {1'b0, best_n});

    always_ff @(posedge mclk) begin
        if (srst) begin
            req_q <= 1'b0;
            line_q <= 5'h00;
            exc_q <= EXC_BASE;
        end else begin
            req_q <= present && !ack_take && !line_moved; // [R17] [R18]
            if (!line_keep) begin
                line_q <= best_n;
                exc_q <= exc_next; // [R9]
            end
        end
    end

    assign irq_req = req_q;
    assign irq_line = line_q;
    assign exc_num = exc_q;

    // Read data
    wire [31:0] rd_mux =
        hit_en ? en_q :
        (hit_ps | hit_pc) ? pend_q :
        hit_path ? path_q :
        hit_trig ? trig_q :
        hit_ch ? {16'h0000, chan_q} :
        hit_plo ? prio_q[31:0] :
        hit_phi ? prio_q[63:32] :
        hit_mask ? {31'h0000_0000, mask_q} :
        hit_act ? act_q :
        hit_st ? {23'h00_0000, req_q, 3'h0, line_q} :
        RST_WORD;

    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata <= RST_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Checks
    a_edge_single: assert property (@(posedge mclk) disable iff (srst) // [R5]
        ((src_evt & $past(src_evt) & edge_sel & $past(edge_sel)) == 0))
        else $error("edge line pulsed twice in a row");

    a_level_repend: assert property (@(posedge mclk) disable iff (srst) // [R4]
        1'b1 |=> ((($past(line_in & ~edge_sel)) & ~pend_q) == 0))
        else $error("high level line not pending");

    a_sw_set_pend: assert property (@(posedge mclk) disable iff (srst) // [R10]
        (wr_en && hit_ps) |=> ((pend_q & $past(pwdata)) == $past(pwdata)))
        else $error("software set did not pend");

    a_sw_clr_pend: assert property (@(posedge mclk) disable iff (srst) // [R11]
        (wr_en && hit_pc) |=> ((pend_q & $past(pwdata & ~src_evt)) == 0))
        else $error("software clear left pending");

    a_exc_map: assert property (@(posedge mclk) disable iff (srst) // [R9]
        irq_req |-> (exc_num == {1'b0, irq_line} + 6'h10))
        else $error("exception number mismatch");

    a_mask_blocks: assert property (@(posedge mclk) disable iff (srst) // [R15]
        mask_q |=> !irq_req)
        else $error("request while masked");

    a_nest_urgent: assert property (@(posedge mclk) disable iff (srst) // [R8]
        $rose(irq_req) |-> ($past(best_p) < $past(act_p)))
        else $error("request not more urgent than active");

    a_ack_enter: assert property (@(posedge mclk) disable iff (srst) // [R18]
        (ack_enter && irq_req) |=> act_q[$past(irq_line)] && !irq_req)
        else $error("entry acknowledge not taken");

    a_enable_gate: assert property (@(posedge mclk) disable iff (srst) // [R12]
        (en_q == 0) |=> !irq_req)
        else $error("request with all lines disabled");

    a_fixed_level: assert property (@(posedge mclk) disable iff (srst) // [R2]
        ((~path_q & fixed_req & ~src_evt) == 0))
        else $error("dedicated request not level treated");

    a_fabric_level: assert property (@(posedge mclk) disable iff (srst) // [R3]
        ((path_q & ~trig_q & line_in & ~src_evt) == 0))
        else $error("fabric level line not pending");

    a_edge_rise: assert property (@(posedge mclk) disable iff (srst) // [R16]
        !$past(srst) |->
        (edge_pulse == (line_in & ~$past(line_in) & edge_sel)))
        else $error("edge pulse not on rising transition");

    a_chan_route: assert property (@(posedge mclk) disable iff (srst) // [R14]
        ($countones(fab_line) == $countones(fabric_ch)))
        else $error("fabric channel not on exactly one line");

    a_req_urgent: assert property (@(posedge mclk) disable iff (srst) // [R17]
        irq_req |-> $past(present))
        else $error("request without more urgent candidate");

    a_line_hold: assert property (@(posedge mclk) disable iff (srst) // [R18]
        (irq_req && $past(irq_req)) |-> $stable(irq_line))
        else $error("presented line changed under request");

    a_ack_clears: assert property (@(posedge mclk) disable iff (srst) // [R18]
        (ack_enter && irq_req) |=>
        ((pend_q & $past(ack_clr & ~src_evt & ~sw_set)) == 0))
        else $error("entry acknowledge left pending");

    a_ack_refused: assert property (@(posedge mclk) disable iff (srst) // [R18]
        (ack_enter && !irq_req) |=> (act_q == $past(act_q & ~exit_clr)))
        else $error("idle acknowledge changed active set");

    a_exit_clears: assert property (@(posedge mclk) disable iff (srst) // [R8]
        ack_exit |=> ((act_q & $past(exit_clr & ~ack_clr)) == 0))
        else $error("exit left line active");

    a_enabled_only: assert property (@(posedge mclk) disable iff (srst) // [R12]
        irq_req |-> $past(cand != 32'h0000_0000))
        else $error("request without enabled pending line");

    a_mask_write: assert property (@(posedge mclk) disable iff (srst) // [R15]
        (wr_en && hit_mask) |=> (mask_q == $past(pwdata[0])))
        else $error("mask write not stored");

    a_exc_floor: assert property (@(posedge mclk) disable iff (srst) // [R9]
        (exc_num >= EXC_BASE))
        else $error("exception number below base");

    a_clr_only: assert property (@(posedge mclk) disable iff (srst) // [R11]
        (wr_en && hit_pc) |=> (en_q == $past(en_q)))
        else $error("pending clear touched enable");

    c_nested: cover property (@(posedge mclk) disable iff (srst)
        ack_enter && irq_req && (act_q != 0));
    c_edge_evt: cover property (@(posedge mclk) disable iff (srst)
        (edge_pulse != 0));
    c_mask_hold: cover property (@(posedge mclk) disable iff (srst)
        mask_q && (pend_q & en_q) != 0);
    c_sw_present: cover property (@(posedge mclk) disable iff (srst)
        (wr_en && hit_ps) ##2 irq_req);
    c_level_again: cover property (@(posedge mclk) disable iff (srst)
        ack_enter && irq_req && ((fixed_req & en_q) != 0));
endmodule

// *** bench/ivc_core_model.sv ***
// Behavioural core that takes and leaves vectored services
`timescale 1ns/1ns
module ivc_core_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic irq_req,
    input wire logic [4:0] irq_line,
    input wire logic hold,
    input wire logic ret,
    output logic ack_enter,
    output logic ack_exit,
    output logic [4:0] ack_exit_line,
    output logic [7:0] entries,
    output logic [4:0] last_line
);
    logic [4:0] stk [4];
    logic [2:0] sp;
    always_ff @(posedge mclk) begin
        ack_enter <= 1'b0;
        ack_exit <= 1'b0;
        ack_exit_line <= ~ack_exit_line;
        if (srst) begin
            sp <= 3'h0;
            ack_exit_line <= 5'h00;
            entries <= 8'h00;
            last_line <= 5'h00;
        end else if (irq_req && !ack_enter && !hold && sp < 3'h4) begin
            ack_enter <= 1'b1;
            stk[sp[1:0]] <= irq_line;
            sp <= sp + 3'h1;
            entries <= entries + 8'h01;
            last_line <= irq_line;
        end else if (ret && sp != 3'h0 && !ack_exit) begin
            ack_exit <= 1'b1;
            ack_exit_line <= stk[sp[1:0] - 2'h1];
            sp <= sp - 3'h1;
        end
    end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
module tb;
    import ivc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d;} ivc_row_s;
    logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic hold = 0, ret = 1, pready, pslverr, irq_req, ack_enter, ack_exit;
    logic err;
    logic [31:0] fixed_req = 0, pwdata = 0, prdata, rd;
    logic [7:0] fabric_ch = 0, paddr = 0, entries, e0;
    logic [4:0] irq_line, ack_exit_line, last_line;
    logic [5:0] exc_num;
    int fails = 0, compares = 0;
    ivc_row_s rows [5] = '{'{OFS_ENABLE, 32'hffff_ffff},
        '{OFS_PATH_SEL, 32'h0000_f0f0}, '{OFS_TRIG_CFG, 32'h0f0f_0000},
        '{OFS_PRIO_HI, 32'h1234_5678}, '{OFS_MASK, 32'h0000_0001}};
    `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
        fails++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
    always #20 mclk = ~mclk;
    ivc_top ivc_top_inst (.mclk(mclk), .srst(srst), .fixed_req(fixed_req),
        .fabric_ch(fabric_ch), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .irq_line(irq_line), .exc_num(exc_num),
        .ack_enter(ack_enter), .ack_exit(ack_exit),
        .ack_exit_line(ack_exit_line));
    ivc_core_model ivc_core_model_inst (.mclk(mclk), .srst(srst),
        .irq_req(irq_req), .irq_line(irq_line), .hold(hold), .ret(ret),
        .ack_enter(ack_enter), .ack_exit(ack_exit),
        .ack_exit_line(ack_exit_line), .entries(entries),
        .last_line(last_line));
    task automatic ap(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wirq();
        for (int n = 0; n < 50 && irq_req !== 1'b1; n++) @(posedge mclk);
        if (irq_req !== 1'b1) fails++;
    endtask
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        `CHK("exc", EXC_BASE, exc_num)
        foreach (rows[i]) begin
            ap(rows[i].a, 0, 0);
            `CHK("rst", RST_WORD, rd)
            ap(rows[i].a, 1, rows[i].d);
            ap(rows[i].a, 0, 0);
            `CHK("rw", rows[i].d, rd)
            ap(rows[i].a, 1, 0);
        end
        ap(8'h30, 1, 32'h1);
        `CHK("slverr", 1'b1, err)
        `CHK("ready", 1'b1, pready)
        $display("registers done");
        ap(OFS_ENABLE, 1, 32'h8);
        fixed_req[3] <= 1'b1;
        wirq();
        `CHK("line", 5'h3, irq_line)
        `CHK("excn", 6'h13, exc_num)
        repeat (30) @(posedge mclk);
        `CHK("relevel", 1'b1, entries > 8'h2)
        fixed_req[3] <= 1'b0;
        repeat (10) @(posedge mclk);
        e0 = entries;
        ap(OFS_CHAN_SEL, 1, 32'h30);
        ap(OFS_PATH_SEL, 1, 32'h800);
        ap(OFS_TRIG_CFG, 1, 32'h800);
        ap(OFS_ENABLE, 1, 32'h800);
        repeat (2) begin
            fabric_ch[2] <= 1'b1;
            repeat (30) @(posedge mclk);
            fabric_ch[2] <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        `CHK("edge", e0 + 8'h2, entries)
        `CHK("chan", 5'hb, last_line)
        $display("triggers done");
        hold <= 1'b1;
        ap(OFS_ENABLE, 1, 0);
        ap(OFS_PEND_SET, 1, 32'h20);
        ap(OFS_PEND_SET, 0, 0);
        `CHK("pend", 32'h20, rd)
        `CHK("off", 1'b0, irq_req)
        ap(OFS_PEND_CLR, 1, 32'h20);
        ap(OFS_ENABLE, 1, 32'h20);
        repeat (4) @(posedge mclk);
        `CHK("clr", 1'b0, irq_req)
        ap(OFS_PEND_SET, 1, 32'h20);
        wirq();
        `CHK("soft", 5'h5, irq_line)
        ap(OFS_ENABLE, 1, 0);
        ap(OFS_PRIO_LO, 1, 32'h0017_3000);
        ap(OFS_ENABLE, 1, 32'h7c0);
        {ret, hold} <= 2'b00;
        ap(OFS_PEND_SET, 1, 32'h40);
        ap(OFS_PEND_SET, 1, 32'h100);
        repeat (8) @(posedge mclk);
        `CHK("nopre", 1'b0, irq_req)
        ap(OFS_PEND_SET, 1, 32'h80);
        repeat (8) @(posedge mclk);
        `CHK("nest", 5'h7, last_line)
        ap(OFS_ACTIVE, 0, 0);
        `CHK("act", 32'h0000_00c0, rd)
        hold <= 1'b1;
        ap(OFS_PEND_SET, 1, 32'h600);
        ret <= 1'b1;
        wirq();
        `CHK("tie", 5'h9, irq_line)
        ap(OFS_STATUS, 0, 0);
        `CHK("stat", 32'h0000_0109, rd)
        hold <= 1'b0;
        repeat (40) @(posedge mclk);
        hold <= 1'b1;
        ap(OFS_MASK, 1, 32'h1);
        ap(OFS_ENABLE, 1, 32'h1);
        ap(OFS_PEND_SET, 1, 32'h1);
        repeat (4) @(posedge mclk);
        `CHK("mask", 1'b0, irq_req)
        ap(OFS_MASK, 1, 0);
        wirq();
        `CHK("l0", EXC_BASE, exc_num)
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        ap(OFS_ENABLE, 0, 0);
        `CHK("rerst", RST_WORD, rd)
        `CHK("rirq", 1'b0, irq_req)
        $display("nesting done");
        results();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        results();
    end
endmodule
